// [logic/abp_pkg.sv]
`default_nettype none
package abp_pkg;
    // ***
    // register map (byte offsets)
    // ***
    localparam logic [3:0] ADDR_RIGHT_VOLUME = 4'h0;
    localparam logic [3:0] ADDR_LEFT_VOLUME = 4'h1;
    localparam logic [3:0] ADDR_BASS_GAIN = 4'h2;
    localparam logic [3:0] ADDR_MID_GAIN = 4'h3;
    localparam logic [3:0] ADDR_TREBLE_GAIN = 4'h4;
    localparam logic [3:0] ADDR_BASEBAND_CONTROL = 4'h5;
    localparam logic [3:0] ADDR_BARGRAPH_SELECT = 4'h6;
    localparam logic [3:0] ADDR_BARGRAPH_LEVEL = 4'h7;
    localparam logic [3:0] ADDR_IRQ_FLAGS = 4'h8;
    localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h9;
    localparam logic [3:0] ADDR_CORE_IRQ_ENABLE = 4'hA;

    // ***
    // field positions
    // ***
    localparam int CTL_MASTER_BIT = 7;
    localparam int CTL_SURROUND_BIT = 6;
    localparam int CTL_BOOST_BIT = 5;
    localparam int CTL_MIX_BIT = 4;
    localparam int CTL_EQ_DISABLE_BIT = 3;
    localparam int IRQ_REQUEST_BIT = 0;
    localparam int IRQ_READY_BIT = 1;
    localparam int IRQ_CLIP_BIT = 2;
    localparam int IRQ_GP_LSB = 3;
    localparam int CORE_GLOBAL_BIT = 0;
    localparam logic [7:0] CTL_WRITABLE_MASK = 8'hF8;

    // ***
    // reset values and widths
    // ***
    localparam logic [4:0] GAIN_RESET = 5'h03;
    localparam logic [4:0] GAIN_MUTE = 5'h1F;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam int SAMPLE_W = 16;
    localparam int WIDE_W = 24;
    localparam int ACC_W = 18;
    localparam int GAIN_FRAC = 14;
    localparam int NUM_BANDS = 8;
    localparam int LEVEL_LSB = 11;
    localparam int PEAK_DECAY_SHIFT = 4;
    localparam logic signed [15:0] SAMPLE_MAX = 16'sh7FFF;
    localparam logic signed [15:0] SAMPLE_MIN = -16'sh7FFF - 16'sh0001;

    // ***
    // one-pole filter shifts at 48 kHz sample rate
    // ***
    localparam int SHIFT_750HZ = 3;
    localparam int SHIFT_3300HZ = 1;
    localparam int SHIFT_200HZ = 5;

    // code to linear gain, 1.0 = 16'h4000, 2 dB per step
    function automatic logic [15:0] abp_gain(input logic [4:0] code);
        logic [15:0] g;
        case (code)
            5'h00: g = 16'h7FB2;
            5'h01: g = 16'h656E;
            5'h02: g = 16'h5092;
            5'h03: g = 16'h4000;
            5'h04: g = 16'h32D6;
            5'h05: g = 16'h2862;
            5'h06: g = 16'h2013;
            5'h07: g = 16'h197B;
            5'h08: g = 16'h143D;
            5'h09: g = 16'h1013;
            5'h0A: g = 16'h0CC5;
            5'h0B: g = 16'h0A25;
            5'h0C: g = 16'h080F;
            5'h0D: g = 16'h0666;
            5'h0E: g = 16'h0515;
            5'h0F: g = 16'h040A;
            5'h10: g = 16'h0335;
            5'h11: g = 16'h028C;
            5'h12: g = 16'h0206;
            5'h13: g = 16'h019C;
            5'h14: g = 16'h0147;
            5'h15: g = 16'h0104;
            5'h16: g = 16'h00CE;
            5'h17: g = 16'h00A4;
            5'h18: g = 16'h0082;
            5'h19: g = 16'h0067;
            5'h1A: g = 16'h0052;
            5'h1B: g = 16'h0041;
            5'h1C: g = 16'h0034;
            5'h1D: g = 16'h0029;
            5'h1E: g = 16'h0021;
            default: g = 16'h0000;
        endcase
        return g;
    endfunction
endpackage
`default_nettype wire

// [logic/abp_chan_if.sv]
`timescale 1ns/100ps
`default_nettype none
// ***
// tone shaping channel link
// ***
interface abp_chan_if;
    import abp_pkg::*;
    logic in_valid;
    logic signed [SAMPLE_W-1:0] in_sample;
    logic [4:0] bass_band_gain;
    logic [4:0] mid_band_gain;
    logic [4:0] treble_band_gain;
    logic equalizer_disable;
    logic bass_boost_enable;
    logic out_valid;
    logic signed [WIDE_W-1:0] out_shaped;
    logic signed [SAMPLE_W-1:0] out_raw;
    modport ctrl (output in_valid, in_sample, bass_band_gain, mid_band_gain, treble_band_gain,
                  equalizer_disable, bass_boost_enable, input out_valid, out_shaped, out_raw);
    modport chan (input in_valid, in_sample, bass_band_gain, mid_band_gain, treble_band_gain,
                  equalizer_disable, bass_boost_enable, output out_valid, out_shaped, out_raw);
endinterface
`default_nettype wire

// [logic/abp_chan.sv]
`timescale 1ns/100ps
`default_nettype none
module abp_chan
    import abp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    abp_chan_if.chan ch
);
    logic signed [ACC_W-1:0] lp_lo_ff, lp_hi_ff, lp_bb_ff;
    logic signed [ACC_W-1:0] nxt_lp_lo, nxt_lp_hi, nxt_lp_bb, x;
    logic signed [ACC_W-1:0] band_bass, band_mid, band_treble;
    logic signed [ACC_W+16:0] p_bass, p_mid, p_treble;
    logic signed [ACC_W+18:0] eq_sum;
    logic signed [WIDE_W-1:0] nxt_shaped, eq_out;
    logic signed [WIDE_W-1:0] out_shaped_ff;
    logic signed [SAMPLE_W-1:0] out_raw_ff;
    logic out_valid_ff;

    // ***
    // band split and gains
    // ***
    always_comb begin
        x = ACC_W'(ch.in_sample);
        nxt_lp_lo = lp_lo_ff + ((x - lp_lo_ff) >>> SHIFT_750HZ);
        nxt_lp_hi = lp_hi_ff + ((x - lp_hi_ff) >>> SHIFT_3300HZ);
        nxt_lp_bb = lp_bb_ff + ((x - lp_bb_ff) >>> SHIFT_200HZ);
        band_bass = nxt_lp_lo; // [R4]
        band_mid = nxt_lp_hi - nxt_lp_lo; // [R4]
        band_treble = x - nxt_lp_hi; // [R4]
        p_bass = band_bass * $signed({1'b0, abp_gain(ch.bass_band_gain)}); // [R3]
        p_mid = band_mid * $signed({1'b0, abp_gain(ch.mid_band_gain)}); // [R3]
        p_treble = band_treble * $signed({1'b0, abp_gain(ch.treble_band_gain)}); // [R3]
        eq_sum = (ACC_W+19)'(p_bass) + (ACC_W+19)'(p_mid) + (ACC_W+19)'(p_treble);
        // disable skips filtering and band gains
        if (ch.equalizer_disable) begin
            eq_out = WIDE_W'(x); // [R5]
        end else begin
            eq_out = WIDE_W'(eq_sum >>> GAIN_FRAC);
        end
        // doubling content under 200 Hz
        if (ch.bass_boost_enable) begin
            nxt_shaped = eq_out + WIDE_W'(nxt_lp_bb); // [R6]
        end else begin
            nxt_shaped = eq_out;
        end
    end

    // filter state
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            lp_lo_ff <= '0;
            lp_hi_ff <= '0;
            lp_bb_ff <= '0;
        end else if (ch.in_valid) begin
            lp_lo_ff <= nxt_lp_lo;
            lp_hi_ff <= nxt_lp_hi;
            lp_bb_ff <= nxt_lp_bb;
        end
    end

    // output stage, one cycle after the input
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            out_valid_ff <= 1'b0;
            out_shaped_ff <= '0;
            out_raw_ff <= '0;
        end else begin
            out_valid_ff <= ch.in_valid;
            if (ch.in_valid) begin
                out_shaped_ff <= nxt_shaped;
                out_raw_ff <= ch.in_sample;
            end
        end
    end

    assign ch.out_valid = out_valid_ff;
    assign ch.out_shaped = out_shaped_ff;
    assign ch.out_raw = out_raw_ff;
endmodule
`default_nettype wire

// [logic/abp_top.sv]
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// (R1) 5-bit volume per channel, 2 dB steps
// (R2) mute code keeps rate, samples zero
// (R3) bass, mid, treble gains use volume map
// (R4) bands split at 750 and 3300 Hz
// (R5) eq disable bypasses filters and band gains
// (R6) bass boost adds 6 dB below 200 Hz
// (R7) surround widens using both channels together
// (R8) selector picks band, level read back
// (R9) mix adds adc samples to output
// (R10) saturation clips sample, sets clip flag
// (R11) software lowers volume, may enable interrupt
// (R12) eight flags, each with enable bit
// (R13) global enable gates interrupt to core
// (R14) interrupt whenever enabled flag asserted
// (R15) master enable off bypasses all processing
// (R16) flags sticky; irq is gated or
// (R17) clip saturates to signed 16-bit limits
module abp_top
    import abp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic in_valid,
    input wire logic signed [15:0] in_left,
    input wire logic signed [15:0] in_right,
    input wire logic adc_valid,
    input wire logic signed [15:0] adc_sample,
    input wire logic request_set,
    input wire logic ready_set,
    input wire logic [4:0] general_purpose_set,
    output logic out_valid,
    output logic signed [15:0] out_left,
    output logic signed [15:0] out_right,
    output logic irq
);
    // ***
    // control registers
    // ***
    logic [4:0] right_volume_code_ff, left_volume_code_ff;
    logic [4:0] bass_band_gain_ff, mid_band_gain_ff, treble_band_gain_ff;
    logic [7:0] baseband_control_ff;
    logic [2:0] bargraph_band_select_ff;
    logic [7:0] irq_flags_ff, irq_enable_ff;
    logic audio_global_irq_enable_ff;
    logic [7:0] reg_rdata_ff;
    logic [7:0] nxt_rdata;
    logic signed [15:0] adc_ff;
    logic out_valid_ff, irq_ff, clip_event;
    logic signed [15:0] out_left_ff, out_right_ff;
    logic [4:0] bargraph_level;
    logic [7:0] event_set;
    logic baseband_master_enable, surround_enable, mix_enable;

    assign baseband_master_enable = baseband_control_ff[CTL_MASTER_BIT];
    assign surround_enable = baseband_control_ff[CTL_SURROUND_BIT];
    assign mix_enable = baseband_control_ff[CTL_MIX_BIT];

    // register writes
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            right_volume_code_ff <= GAIN_RESET;
            left_volume_code_ff <= GAIN_RESET;
            bass_band_gain_ff <= GAIN_RESET;
            mid_band_gain_ff <= GAIN_RESET;
            treble_band_gain_ff <= GAIN_RESET;
            baseband_control_ff <= BYTE_ZERO;
            bargraph_band_select_ff <= '0;
            irq_enable_ff <= BYTE_ZERO;
            audio_global_irq_enable_ff <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_RIGHT_VOLUME) begin
                right_volume_code_ff <= reg_wdata[4:0]; // [R1]
            end else if (reg_addr == ADDR_LEFT_VOLUME) begin
                left_volume_code_ff <= reg_wdata[4:0]; // [R1]
            end else if (reg_addr == ADDR_BASS_GAIN) begin
                bass_band_gain_ff <= reg_wdata[4:0]; // [R3]
            end else if (reg_addr == ADDR_MID_GAIN) begin
                mid_band_gain_ff <= reg_wdata[4:0]; // [R3]
            end else if (reg_addr == ADDR_TREBLE_GAIN) begin
                treble_band_gain_ff <= reg_wdata[4:0]; // [R3]
            end else if (reg_addr == ADDR_BASEBAND_CONTROL) begin
                baseband_control_ff <= reg_wdata & CTL_WRITABLE_MASK;
            end else if (reg_addr == ADDR_BARGRAPH_SELECT) begin
                bargraph_band_select_ff <= reg_wdata[2:0]; // [R8]
            end else if (reg_addr == ADDR_IRQ_ENABLE) begin
                irq_enable_ff <= reg_wdata; // [R12]
            end else if (reg_addr == ADDR_CORE_IRQ_ENABLE) begin
                audio_global_irq_enable_ff <= reg_wdata[CORE_GLOBAL_BIT]; // [R13]
            end
        end
    end

    // read mux, data stands one cycle
    always_comb begin
        nxt_rdata = BYTE_ZERO;
        if (reg_addr == ADDR_RIGHT_VOLUME) begin
            nxt_rdata = {3'h0, right_volume_code_ff};
        end else if (reg_addr == ADDR_LEFT_VOLUME) begin
            nxt_rdata = {3'h0, left_volume_code_ff};
        end else if (reg_addr == ADDR_BASS_GAIN) begin
            nxt_rdata = {3'h0, bass_band_gain_ff};
        end else if (reg_addr == ADDR_MID_GAIN) begin
            nxt_rdata = {3'h0, mid_band_gain_ff};
        end else if (reg_addr == ADDR_TREBLE_GAIN) begin
            nxt_rdata = {3'h0, treble_band_gain_ff};
        end else if (reg_addr == ADDR_BASEBAND_CONTROL) begin
            nxt_rdata = baseband_control_ff;
        end else if (reg_addr == ADDR_BARGRAPH_SELECT) begin
            nxt_rdata = {5'h00, bargraph_band_select_ff};
        end else if (reg_addr == ADDR_BARGRAPH_LEVEL) begin
            nxt_rdata = {3'h0, bargraph_level}; // [R8]
        end else if (reg_addr == ADDR_IRQ_FLAGS) begin
            nxt_rdata = irq_flags_ff;
        end else if (reg_addr == ADDR_IRQ_ENABLE) begin
            nxt_rdata = irq_enable_ff;
        end else if (reg_addr == ADDR_CORE_IRQ_ENABLE) begin
            nxt_rdata = {7'h00, audio_global_irq_enable_ff};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata_ff <= BYTE_ZERO;
        end else if (reg_rd) begin
            reg_rdata_ff <= nxt_rdata;
        end else begin
            reg_rdata_ff <= BYTE_ZERO;
        end
    end

    // latest adc sample
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            adc_ff <= '0;
        end else if (adc_valid) begin
            adc_ff <= adc_sample;
        end
    end

    // ***
    // tone shaping, one unit per channel
    // ***
    abp_chan_if left_if ();
    abp_chan_if right_if ();

    assign left_if.in_valid = in_valid;
    assign left_if.in_sample = in_left;
    assign right_if.in_valid = in_valid;
    assign right_if.in_sample = in_right;
    assign left_if.bass_band_gain = bass_band_gain_ff;
    assign right_if.bass_band_gain = bass_band_gain_ff;
    assign left_if.mid_band_gain = mid_band_gain_ff;
    assign right_if.mid_band_gain = mid_band_gain_ff;
    assign left_if.treble_band_gain = treble_band_gain_ff;
    assign right_if.treble_band_gain = treble_band_gain_ff;
    assign left_if.equalizer_disable = baseband_control_ff[CTL_EQ_DISABLE_BIT];
    assign right_if.equalizer_disable = baseband_control_ff[CTL_EQ_DISABLE_BIT];
    assign left_if.bass_boost_enable = baseband_control_ff[CTL_BOOST_BIT];
    assign right_if.bass_boost_enable = baseband_control_ff[CTL_BOOST_BIT];

    abp_chan u_left (
        .sys_clk(sys_clk),
        .rst(rst),
        .ch(left_if)
    );

    abp_chan u_right (
        .sys_clk(sys_clk),
        .rst(rst),
        .ch(right_if)
    );

    // ***
    // surround, volume, mix, saturation
    // ***
    logic signed [WIDE_W:0] sur_l, sur_r;
    logic signed [WIDE_W+17:0] vol_l, vol_r;
    logic signed [WIDE_W+4:0] mix_l, mix_r;
    logic signed [15:0] sat_l, sat_r;
    logic clip_l, clip_r;

    always_comb begin
        // cross-feed of the channel difference
        if (surround_enable) begin
            sur_l = (WIDE_W+1)'(left_if.out_shaped) + ((left_if.out_shaped - right_if.out_shaped) >>> 1); // [R7]
            sur_r = (WIDE_W+1)'(right_if.out_shaped) + ((right_if.out_shaped - left_if.out_shaped) >>> 1); // [R7]
        end else begin
            sur_l = (WIDE_W+1)'(left_if.out_shaped);
            sur_r = (WIDE_W+1)'(right_if.out_shaped);
        end
        vol_l = sur_l * $signed({1'b0, abp_gain(left_volume_code_ff)}); // [R1]
        vol_r = sur_r * $signed({1'b0, abp_gain(right_volume_code_ff)}); // [R1]
        mix_l = (WIDE_W+5)'(vol_l >>> GAIN_FRAC);
        mix_r = (WIDE_W+5)'(vol_r >>> GAIN_FRAC);
        if (mix_enable) begin
            mix_l = mix_l + (WIDE_W+5)'(adc_ff); // [R9]
            mix_r = mix_r + (WIDE_W+5)'(adc_ff); // [R9]
        end
        // saturate rather than wrap
        clip_l = 1'b1;
        clip_r = 1'b1;
        if (mix_l > (WIDE_W+5)'(SAMPLE_MAX)) begin
            sat_l = SAMPLE_MAX; // [R17]
        end else if (mix_l < (WIDE_W+5)'(SAMPLE_MIN)) begin
            sat_l = SAMPLE_MIN; // [R17]
        end else begin
            sat_l = mix_l[15:0];
            clip_l = 1'b0;
        end
        if (mix_r > (WIDE_W+5)'(SAMPLE_MAX)) begin
            sat_r = SAMPLE_MAX; // [R17]
        end else if (mix_r < (WIDE_W+5)'(SAMPLE_MIN)) begin
            sat_r = SAMPLE_MIN; // [R17]
        end else begin
            sat_r = mix_r[15:0];
            clip_r = 1'b0;
        end
        // mute forces zero, rate kept
        if (left_volume_code_ff == GAIN_MUTE) begin
            sat_l = '0; // [R2]
            clip_l = 1'b0;
        end
        if (right_volume_code_ff == GAIN_MUTE) begin
            sat_r = '0; // [R2]
            clip_r = 1'b0;
        end
        clip_event = left_if.out_valid && baseband_master_enable && (clip_l || clip_r); // [R10]
    end

    // output sample register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            out_valid_ff <= 1'b0;
            out_left_ff <= '0;
            out_right_ff <= '0;
        end else begin
            out_valid_ff <= left_if.out_valid; // [R2]
            if (left_if.out_valid) begin
                if (baseband_master_enable) begin
                    out_left_ff <= sat_l; // [R10]
                    out_right_ff <= sat_r; // [R10]
                end else begin
                    out_left_ff <= left_if.out_raw; // [R15]
                    out_right_ff <= right_if.out_raw; // [R15]
                end
            end
        end
    end

    // ***
    // bar-graph: eight band peak meters
    // ***
    logic signed [ACC_W-1:0] mono;
    logic signed [ACC_W-1:0] lp_ff [NUM_BANDS];
    logic [15:0] peak_ff [NUM_BANDS];
    assign mono = (ACC_W'(in_left) + ACC_W'(in_right)) >>> 1;
    assign lp_ff[0] = mono;

    genvar gi;
    generate
        for (gi = 1; gi < NUM_BANDS; gi++) begin : g_lp
            // lower cutoff as index grows
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    lp_ff[gi] <= '0;
                end else if (in_valid) begin
                    lp_ff[gi] <= lp_ff[gi] + ((lp_ff[gi-1] - lp_ff[gi]) >>> gi);
                end
            end
        end
        for (gi = 0; gi < NUM_BANDS; gi++) begin : g_peak
            logic signed [ACC_W-1:0] band;
            logic [ACC_W-1:0] mag;
            // band 0 lowest, band 7 highest
            if (gi == 0) begin : g_low
                assign band = lp_ff[NUM_BANDS-1];
            end else begin : g_mid
                assign band = lp_ff[NUM_BANDS-1-gi] - lp_ff[NUM_BANDS-gi];
            end
            assign mag = band[ACC_W-1] ? ACC_W'(-band) : ACC_W'(band);
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    peak_ff[gi] <= '0;
                end else if (in_valid) begin
                    if (|mag[ACC_W-1:16] || mag[15:0] > peak_ff[gi]) begin
                        peak_ff[gi] <= (|mag[ACC_W-1:16]) ? 16'hFFFF : mag[15:0];
                    end else begin
                        peak_ff[gi] <= peak_ff[gi] - (peak_ff[gi] >> PEAK_DECAY_SHIFT);
                    end
                end
            end
        end
    endgenerate

    assign bargraph_level = peak_ff[bargraph_band_select_ff][LEVEL_LSB+4:LEVEL_LSB]; // [R8]

    // ***
    // interrupt flags
    // ***
    always_comb begin
        event_set = BYTE_ZERO;
        event_set[IRQ_REQUEST_BIT] = request_set; // [R12]
        event_set[IRQ_READY_BIT] = ready_set; // [R12]
        event_set[IRQ_CLIP_BIT] = clip_event; // [R10]
        event_set[IRQ_GP_LSB+4:IRQ_GP_LSB] = general_purpose_set; // [R12]
    end

    // sticky, write one clears, set beats clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_flags_ff <= BYTE_ZERO;
        end else if (reg_wr && reg_addr == ADDR_IRQ_FLAGS) begin
            irq_flags_ff <= (irq_flags_ff & ~reg_wdata) | event_set; // [R16]
        end else begin
            irq_flags_ff <= irq_flags_ff | event_set; // [R16]
        end
    end

    // gated or of enabled flags
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= audio_global_irq_enable_ff && |(irq_flags_ff & irq_enable_ff); // [R13] [R14]
        end
    end

    assign reg_rdata = reg_rdata_ff;
    assign out_valid = out_valid_ff;
    assign out_left = out_left_ff;
    assign out_right = out_right_ff;
    assign irq = irq_ff;
endmodule
`default_nettype wire

// [test/abp_checker.sv]
`timescale 1ns/100ps
`default_nettype none
// ***
// port checks
// ***
module abp_checker
    import abp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic in_valid,
    input wire logic signed [15:0] in_left,
    input wire logic signed [15:0] in_right,
    input wire logic request_set,
    input wire logic out_valid,
    input wire logic signed [15:0] out_left,
    input wire logic signed [15:0] out_right,
    input wire logic irq
);
    logic [4:0] rvol_ff;
    logic [7:0] ctl_ff;
    logic req_en_ff, glb_ff;
    // shadow of steering writes
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rvol_ff <= GAIN_RESET;
            ctl_ff <= BYTE_ZERO;
            req_en_ff <= 1'b0;
            glb_ff <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_RIGHT_VOLUME) rvol_ff <= reg_wdata[4:0];
            if (reg_addr == ADDR_BASEBAND_CONTROL) ctl_ff <= reg_wdata;
            if (reg_addr == ADDR_IRQ_ENABLE) req_en_ff <= reg_wdata[IRQ_REQUEST_BIT];
            if (reg_addr == ADDR_CORE_IRQ_ENABLE) glb_ff <= reg_wdata[CORE_GLOBAL_BIT];
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_valid_two_later: assert property (in_valid |-> ##2 out_valid) else $error("out_valid late");
    a_no_stray_valid: assert property (out_valid |-> $past(in_valid, 2)) else $error("stray out_valid");
    a_bypass_raw: assert property (out_valid && !ctl_ff[CTL_MASTER_BIT] && $past(ctl_ff, 3) == ctl_ff
        |-> out_left == $past(in_left, 2) && out_right == $past(in_right, 2)) else $error("bypass altered");
    a_mute_zero: assert property (out_valid && ctl_ff[CTL_MASTER_BIT] && !ctl_ff[CTL_MIX_BIT]
        && $past(ctl_ff, 3) == ctl_ff && rvol_ff == GAIN_MUTE && $past(rvol_ff, 3) == GAIN_MUTE
        |-> out_right == 16'sh0000) else $error("mute not zero");
    a_rdata_after_read: assert property (reg_rdata != 8'h00 |-> $past(reg_rd)) else $error("stray rdata");
    a_irq_request: assert property (request_set && req_en_ff && glb_ff |-> ##2 irq) else $error("irq missing");
    a_irq_gated: assert property (irq |-> $past(glb_ff)) else $error("irq without global");
    a_irq_fall_cause: assert property ($fell(irq) && !$past(rst) |-> $past(reg_wr, 2) || $past(reg_wr, 3))
        else $error("irq dropped alone");
endmodule
bind abp_top abp_checker chk_u (.*);
`default_nettype wire

// [test/abp_src_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ***
// upstream sample source
// ***
module abp_src_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic send,
    input wire logic signed [15:0] left,
    input wire logic signed [15:0] right,
    output logic in_valid,
    output logic signed [15:0] in_left,
    output logic signed [15:0] in_right
);
    // one pair per send, lines scrambled between pairs
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            in_valid <= 1'b0;
            in_left <= 16'sh0000;
            in_right <= 16'sh0000;
        end else begin
            in_valid <= send;
            in_left <= send ? left : ~in_left;
            in_right <= send ? right : ~in_right;
        end
    end
endmodule
`default_nettype wire

// [test/audio_baseband_post_processor_bench.sv]
`timescale 1ns/100ps
`default_nettype none
// ***
// bench
// ***
module audio_baseband_post_processor_bench;
    import abp_pkg::*;
    logic sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, send = 1'b0;
    logic adc_valid = 1'b0, request_set = 1'b0, ready_set = 1'b0, in_valid, out_valid, irq;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic [4:0] general_purpose_set = 5'h00;
    logic signed [15:0] sl = 16'sh0000, sr = 16'sh0000, adc_sample = 16'sh0000;
    logic signed [15:0] in_left, in_right, out_left, out_right;
    int bad_count = 0, compares = 0, cyc = 0;
    abp_src_model src_u (.sys_clk, .rst, .send, .left(sl), .right(sr), .in_valid, .in_left, .in_right);
    abp_top dut_u (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .in_valid, .in_left,
        .in_right, .adc_valid, .adc_sample, .request_set, .ready_set, .general_purpose_set, .out_valid,
        .out_left, .out_right, .irq);
    // clock and hang guard
    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            stop_test();
        end
    end
    task stop_test();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task chk(input logic [15:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    task rd(input logic [3:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk({8'h00, reg_rdata}, {8'h00, e});
        @(posedge sys_clk);
    endtask
    task pair(input logic signed [15:0] l, r, el, er);
        int n;
        n = 0;
        send <= 1'b1;
        sl <= l;
        sr <= r;
        @(posedge sys_clk);
        send <= 1'b0;
        do begin
            @(posedge sys_clk);
            #1 n++;
        end while (out_valid !== 1'b1 && n < 8);
        chk(out_left, el);
        chk(out_right, er);
        @(posedge sys_clk);
    endtask
    task irq_is(input logic e);
        repeat (3) @(posedge sys_clk);
        #1 chk({15'h0000, irq}, {15'h0000, e});
        @(posedge sys_clk);
    endtask
    task t_regs();
        rd(ADDR_RIGHT_VOLUME, {3'b000, GAIN_RESET});
        rd(ADDR_BASS_GAIN, {3'b000, GAIN_RESET});
        wr(ADDR_BASEBAND_CONTROL, 8'hFF);
        rd(ADDR_BASEBAND_CONTROL, CTL_WRITABLE_MASK);
        rd(4'hF, 8'h00);
        wr(ADDR_BARGRAPH_SELECT, 8'h07);
        rd(ADDR_BARGRAPH_SELECT, 8'h07);
        wr(ADDR_MID_GAIN, 8'h07);
        wr(ADDR_BASEBAND_CONTROL, 8'h80);
        rd(ADDR_MID_GAIN, 8'h07);
    endtask
    task t_stream();
        wr(ADDR_BASEBAND_CONTROL, 8'h00);
        pair(16'sd1234, -16'sd77, 16'sd1234, -16'sd77);
        wr(ADDR_BASEBAND_CONTROL, 8'h88);
        pair(16'sd1000, -16'sd2000, 16'sd1000, -16'sd2000);
        adc_sample <= 16'sd500;
        adc_valid <= 1'b1;
        @(posedge sys_clk);
        adc_valid <= 1'b0;
        wr(ADDR_BASEBAND_CONTROL, 8'h98);
        pair(16'sd1000, -16'sd2000, 16'sd1500, -16'sd1500);
        wr(ADDR_BASEBAND_CONTROL, 8'hC8);
        pair(16'sd1000, 16'sd0, 16'sd1500, -16'sd500);
        wr(ADDR_RIGHT_VOLUME, {3'b000, GAIN_MUTE});
        wr(ADDR_BASEBAND_CONTROL, 8'h88);
        pair(16'sd100, 16'sd100, 16'sd100, 16'sd0);
        wr(ADDR_RIGHT_VOLUME, 8'h00);
        wr(ADDR_LEFT_VOLUME, 8'h00);
        pair(16'sh7000, -16'sh7000, SAMPLE_MAX, SAMPLE_MIN);
        rd(ADDR_IRQ_FLAGS, 8'h04);
        wr(ADDR_LEFT_VOLUME, {3'b000, GAIN_RESET});
        wr(ADDR_IRQ_FLAGS, 8'h04);
        rd(ADDR_IRQ_FLAGS, 8'h00);
    endtask
    task t_irq();
        wr(ADDR_IRQ_ENABLE, 8'h01);
        wr(ADDR_CORE_IRQ_ENABLE, 8'h01);
        request_set <= 1'b1;
        @(posedge sys_clk);
        request_set <= 1'b0;
        irq_is(1'b1);
        ready_set <= 1'b1;
        general_purpose_set <= 5'h1F;
        @(posedge sys_clk);
        ready_set <= 1'b0;
        general_purpose_set <= 5'h00;
        rd(ADDR_IRQ_FLAGS, 8'hFB);
        wr(ADDR_IRQ_ENABLE, 8'h00);
        irq_is(1'b0);
        wr(ADDR_IRQ_ENABLE, 8'h01);
        wr(ADDR_CORE_IRQ_ENABLE, 8'h00);
        irq_is(1'b0);
        wr(ADDR_CORE_IRQ_ENABLE, 8'h01);
        wr(ADDR_IRQ_FLAGS, 8'hFF);
        irq_is(1'b0);
    endtask
    // main sequence
    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        t_regs();
        t_stream();
        t_irq();
        stop_test();
    end
endmodule
`default_nettype wire
